// >>> design/crf_alu.sv
// Single-cycle combinational ALU with flag generation
module crf_alu
    import crf_pkg::*;
(
    // Operands in, results and flags out
    crf_alu_if.alu p
);
    logic cin;
    logic [7:0] sa;
    logic [7:0] sb;
    logic [8:0] add9;
    logic [8:0] sub9;
    logic [15:0] prod;
    logic [15:0] w16;
    logic [7:0] r;
    logic [15:0] w;
    logic h, v, n, z, c, t, wide;

    assign cin = ((p.op == CRF_OP_ADC) || (p.op == CRF_OP_SBC)) && p.flags_in[CRF_FB_C];
    assign sa = (p.op == CRF_OP_NEG) ? 8'h00 : p.a;
    assign sb = (p.op == CRF_OP_NEG) ? p.a : p.b;
    assign add9 = {1'b0, sa} + {1'b0, sb} + {8'h00, cin};
    assign sub9 = {1'b0, sa} - {1'b0, sb} - {8'h00, cin};
    assign prod = {8'h00, p.a} * {8'h00, p.b};
    assign w16 = (p.op == CRF_OP_SBIW) ? p.a16 - {8'h00, p.b} : p.a16 + {8'h00, p.b};

    always_comb begin
        r = p.a;
        w = p.a16;
        h = p.flags_in[CRF_FB_H];
        v = p.flags_in[CRF_FB_V];
        c = p.flags_in[CRF_FB_C];
        t = p.flags_in[CRF_FB_T];
        wide = 1'b0;
        p.mask = 8'h00;
        unique case (p.op)
            CRF_OP_ADD, CRF_OP_ADC: begin
                r = add9[7:0];
                h = sa[3] & sb[3] | sb[3] & ~r[3] | ~r[3] & sa[3];
                v = sa[7] & sb[7] & ~r[7] | ~sa[7] & ~sb[7] & r[7];
                c = add9[8];
                p.mask = CRF_M_ARITH;
            end
            CRF_OP_SUB, CRF_OP_SBC, CRF_OP_NEG: begin
                r = sub9[7:0];
                h = ~sa[3] & sb[3] | sb[3] & r[3] | r[3] & ~sa[3];
                v = sa[7] & ~sb[7] & ~r[7] | ~sa[7] & sb[7] & r[7];
                c = sub9[8];
                p.mask = CRF_M_ARITH;
            end
            CRF_OP_AND, CRF_OP_OR, CRF_OP_EOR: begin
                r = (p.op == CRF_OP_AND) ? (p.a & p.b) :
                    (p.op == CRF_OP_OR) ? (p.a | p.b) : (p.a ^ p.b);
                v = 1'b0;
                p.mask = CRF_M_SVNZ;
            end
            CRF_OP_COM: begin
                r = ~p.a;
                v = 1'b0;
                c = 1'b1;
                p.mask = CRF_M_SVNZC;
            end
            CRF_OP_INC, CRF_OP_DEC: begin
                r = (p.op == CRF_OP_INC) ? p.a + 8'h01 : p.a - 8'h01;
                v = (p.op == CRF_OP_INC) ? (r == 8'h80) : (r == 8'h7F);
                p.mask = CRF_M_SVNZ;
            end
            CRF_OP_LSR, CRF_OP_ROR, CRF_OP_ASR: begin
                r = {(p.op == CRF_OP_ROR) ? p.flags_in[CRF_FB_C] :
                     (p.op == CRF_OP_ASR) ? p.a[7] : 1'b0, p.a[7:1]};
                c = p.a[0];
                v = r[7] ^ p.a[0];
                p.mask = CRF_M_SVNZC;
            end
            CRF_OP_SWAP: r = {p.a[3:0], p.a[7:4]};
            CRF_OP_MOV: r = p.b;
            CRF_OP_BIT_TO_T: begin
                t = p.a[p.bit_sel];
                p.mask = CRF_M_T;
            end
            CRF_OP_T_TO_BIT: r[p.bit_sel] = p.flags_in[CRF_FB_T];
            CRF_OP_MUL: begin
                w = prod;
                wide = 1'b1;
                c = prod[15];
                p.mask = CRF_M_ZC;
            end
            CRF_OP_ADIW, CRF_OP_SBIW: begin
                w = w16;
                wide = 1'b1;
                v = (p.op == CRF_OP_ADIW) ? (~p.a16[15] & w16[15]) : (p.a16[15] & ~w16[15]);
                c = (p.op == CRF_OP_ADIW) ? (~w16[15] & p.a16[15]) : (w16[15] & ~p.a16[15]);
                p.mask = CRF_M_SVNZC;
            end
            CRF_OP_MOVW: wide = 1'b1;
            CRF_OP_NOP, CRF_OP_PUSH, CRF_OP_POP, CRF_OP_CALL, CRF_OP_RET, CRF_OP_IRET,
            CRF_OP_IRQ, CRF_OP_SEI, CRF_OP_CLI: r = p.a;
            default: r = p.a;
        endcase
        n = wide ? w[15] : r[7];
        z = wide ? (w == 16'h0000) :
            ((r == 8'h00) && ((p.op != CRF_OP_SBC) || p.flags_in[CRF_FB_Z]));
        p.res8 = r;
        p.res16 = w;
        p.flags_out = {p.flags_in[CRF_FB_I], t, h, n ^ v, v, n, z, c};
    end
endmodule

// >>> design/crf_alu_if.sv
// Operand and result bundle between the core and its ALU
interface crf_alu_if;
    import crf_pkg::*;
    crf_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] a16;
    logic [7:0] flags_in;
    logic [2:0] bit_sel;
    logic [7:0] res8;
    logic [15:0] res16;
    logic [7:0] flags_out;
    logic [7:0] mask;
    modport alu (input op, a, b, a16, flags_in, bit_sel, output res8, res16, flags_out, mask);
    modport core (output op, a, b, a16, flags_in, bit_sel, input res8, res16, flags_out, mask);
endinterface

// >>> design/crf_core.sv
// Working registers, flag register and stack pointer of the 8-bit core
// What this block does
// - ALU op completes in one clock cycle
// - ALU ops other than SWAP, MOV, MOVW and flag-to-bit copy update the flag register
// - Flags not saved or restored on interrupts
// - Global enable clear blocks every interrupt
// - Interrupt entry clears enable; return sets it
// - Bit-copy flag to and from register bit
// - Half carry from low nibble on arithmetic
// - Sign flag always equals negative xor overflow
// - Overflow flag marks two's-complement overflow
// - Negative flag follows result sign bit
// - Zero flag set on zero result; after SBC only if it was already set
// - Carry flag records arithmetic or logic carry
// - Four read/write patterns, 8 and 16 bit
// - Working registers mirror data addresses 0x00-0x1F
// - Three pointer pairs, displacement, post-inc, pre-dec
// - Stack grows downward; push decrements pointer
// - Stack moves one for data, two for addresses
// - Stack pointer resets to SRAM top address
// - Stack pointer as two 8-bit I/O registers
// - Core clock used undivided
// - Read, execute and write back in one cycle
// - I/O registers mirrored at data 0x20-0x5F
module crf_core
    import crf_pkg::*;
#(
    parameter int SP_W = CRF_SP_W_DEF,
    parameter logic [15:0] SRAM_TOP = CRF_SRAM_TOP_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Instruction from the decoder
    input wire logic op_valid,
    input wire crf_op_t op,
    input wire logic [4:0] dst_idx,
    input wire logic [4:0] src_idx,
    input wire logic [7:0] imm,
    input wire logic use_imm,
    input wire logic [2:0] bit_sel,
    // Pointer addressing
    input wire logic ptr_req,
    input wire logic [1:0] ptr_sel,
    input wire crf_ptr_mode_t ptr_mode,
    input wire logic [5:0] ptr_disp,
    output logic [15:0] ptr_addr_r,
    // Data-space access
    input wire logic ds_rd,
    input wire logic ds_wr,
    input wire logic [15:0] ds_addr,
    input wire logic [7:0] ds_wdata,
    output logic [7:0] ds_rdata_r,
    output logic ds_hit_r,
    // Interrupt gating and core state
    input wire logic irq_req,
    output logic irq_ok_r,
    output logic [7:0] flags_r,
    output logic [15:0] sp_r
);
    // ------------------------------------------------------------
    // Parameter checks and constants
    // ------------------------------------------------------------
    if (SP_W < 8 || SP_W > 16) begin : g_bad_sp_w
        $error("SP_W must lie between 8 and 16");
    end
    localparam logic [15:0] SP_MASK = 16'((32'h1 << SP_W) - 1);
    localparam logic [15:0] SP_RST = SRAM_TOP & SP_MASK;
    localparam bit HAS_SP_HI = (SP_W > 8);

    logic [7:0] gpr_r [CRF_NUM_GPR];
    logic [7:0] flags_nxt;
    logic [15:0] sp_nxt;

    crf_alu_if alu_bus ();
    crf_alu u_alu (.p(alu_bus));

    // ------------------------------------------------------------
    // Operand fetch and op classes
    // ------------------------------------------------------------
    wire logic [4:0] dst_even = {dst_idx[4:1], 1'b0};
    wire logic [4:0] dst_odd = {dst_idx[4:1], 1'b1};
    wire logic [4:0] src_even = {src_idx[4:1], 1'b0};
    wire logic [4:0] src_odd = {src_idx[4:1], 1'b1};
    wire logic is_alu = op_valid && (op inside {[CRF_OP_ADD:CRF_OP_MOVW]});
    wire logic is_w16 = op_valid && (op inside {CRF_OP_MUL, CRF_OP_ADIW, CRF_OP_SBIW, CRF_OP_MOVW});
    wire logic is_w8 = op_valid && (op inside {[CRF_OP_ADD:CRF_OP_MOV], CRF_OP_T_TO_BIT});
    wire logic gie_set = op_valid && (op inside {CRF_OP_IRET, CRF_OP_SEI});
    wire logic gie_clr = op_valid && (op inside {CRF_OP_IRQ, CRF_OP_CLI});

    // Two 8-bit reads, or one 16-bit pair read
    assign alu_bus.op = op;
    assign alu_bus.a = gpr_r[dst_idx];
    assign alu_bus.b = use_imm ? imm : gpr_r[src_idx];
    assign alu_bus.a16 = (op == CRF_OP_MOVW) ? {gpr_r[src_odd], gpr_r[src_even]} :
                         {gpr_r[dst_odd], gpr_r[dst_even]};
    assign alu_bus.flags_in = flags_r;
    assign alu_bus.bit_sel = bit_sel;

    // ------------------------------------------------------------
    // Data-space decode
    // ------------------------------------------------------------
    wire logic ds_gpr = ds_addr < CRF_IO_BASE;
    wire logic ds_io = (ds_addr >= CRF_IO_BASE) && (ds_addr <= CRF_IO_LAST);
    wire logic [15:0] io_full = ds_addr - CRF_IO_BASE;
    wire logic [5:0] io_off = io_full[5:0];
    wire logic ds_sp_lo = ds_io && (io_off == CRF_SP_LO_IO);
    wire logic ds_sp_hi = ds_io && (io_off == CRF_SP_HI_IO) && HAS_SP_HI;
    wire logic ds_flags = ds_io && (io_off == CRF_FLAGS_IO);
    wire logic ds_hit = ds_gpr || ds_sp_lo || ds_sp_hi || ds_flags;
    wire logic [7:0] rd_gpr = gpr_r[ds_addr[4:0]];
    wire logic [7:0] rd_val = ds_gpr ? rd_gpr : ds_sp_lo ? sp_r[7:0] :
                              ds_sp_hi ? sp_r[15:8] : ds_flags ? flags_r : 8'h00;
    wire logic gpr_ds_wr = ds_wr && ds_gpr;

    // ------------------------------------------------------------
    // Pointer pairs
    // ------------------------------------------------------------
    wire logic [4:0] ptr_lo = CRF_PTR_X + {2'b00, ptr_sel, 1'b0};
    wire logic [4:0] ptr_hi = ptr_lo | 5'h01;
    wire logic [15:0] ptr_base = {gpr_r[ptr_hi], gpr_r[ptr_lo]};
    wire logic ptr_go = ptr_req && (ptr_sel != 2'b11);
    wire logic ptr_upd = ptr_go && (ptr_mode != CRF_PM_DISP);
    wire logic [15:0] ptr_inc = ptr_base + CRF_STEP_DATA;
    wire logic [15:0] ptr_dec = ptr_base - CRF_STEP_DATA;
    wire logic [15:0] ptr_eff = (ptr_mode == CRF_PM_PREDEC) ? ptr_dec :
                                (ptr_mode == CRF_PM_DISP) ? ptr_base + {10'h000, ptr_disp} :
                                ptr_base;
    wire logic [15:0] ptr_new = (ptr_mode == CRF_PM_POSTINC) ? ptr_inc : ptr_dec;

    // ------------------------------------------------------------
    // Register file write ports
    // ------------------------------------------------------------
    // One write per cycle is expected; the data-space path wins, then pointers.
    wire logic [4:0] w16_lo = (op == CRF_OP_MUL) ? CRF_MUL_DST : dst_even;
    wire logic we_lo = gpr_ds_wr || ptr_upd || is_w8 || is_w16;
    wire logic [4:0] wa_lo = gpr_ds_wr ? ds_addr[4:0] : ptr_upd ? ptr_lo :
                             is_w16 ? w16_lo : dst_idx;
    wire logic [7:0] wd_lo = gpr_ds_wr ? ds_wdata : ptr_upd ? ptr_new[7:0] :
                             is_w16 ? alu_bus.res16[7:0] : alu_bus.res8;
    wire logic we_hi = !gpr_ds_wr && (ptr_upd || is_w16);
    wire logic [4:0] wa_hi = ptr_upd ? ptr_hi : (w16_lo | 5'h01);
    wire logic [7:0] wd_hi = ptr_upd ? ptr_new[15:8] : alu_bus.res16[15:8];

    for (genvar g = 0; g < CRF_NUM_GPR; g++) begin : g_gpr
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                gpr_r[g] <= CRF_GPR_RST;
            end else if (we_lo && wa_lo == 5'(g)) begin
                gpr_r[g] <= wd_lo;
            end else if (we_hi && wa_hi == 5'(g)) begin
                gpr_r[g] <= wd_hi;
            end
        end
    end

    // ------------------------------------------------------------
    // Flag and stack pointer next state
    // ------------------------------------------------------------
    // Interrupt entry and return touch only the enable bit; the rest is software's job.
    always_comb begin
        flags_nxt = flags_r;
        if (ds_wr && ds_flags) begin
            flags_nxt = ds_wdata;
        end else if (is_alu) begin
            flags_nxt = (flags_r & ~alu_bus.mask) | (alu_bus.flags_out & alu_bus.mask);
        end else if (gie_clr) begin
            flags_nxt[CRF_FB_I] = 1'b0;
        end else if (gie_set) begin
            flags_nxt[CRF_FB_I] = 1'b1;
        end
        flags_nxt[CRF_FB_S] = flags_nxt[CRF_FB_N] ^ flags_nxt[CRF_FB_V];
    end

    always_comb begin
        sp_nxt = sp_r;
        if (ds_wr && ds_sp_lo) begin
            sp_nxt[7:0] = ds_wdata;
        end else if (ds_wr && ds_sp_hi) begin
            sp_nxt[15:8] = ds_wdata;
        end else if (op_valid && op == CRF_OP_PUSH) begin
            sp_nxt = sp_r - CRF_STEP_DATA;
        end else if (op_valid && op == CRF_OP_POP) begin
            sp_nxt = sp_r + CRF_STEP_DATA;
        end else if (op_valid && (op inside {CRF_OP_CALL, CRF_OP_IRQ})) begin
            sp_nxt = sp_r - CRF_STEP_ADDR;
        end else if (op_valid && (op inside {CRF_OP_RET, CRF_OP_IRET})) begin
            sp_nxt = sp_r + CRF_STEP_ADDR;
        end
        sp_nxt = sp_nxt & SP_MASK;
    end

    // ------------------------------------------------------------
    // State and output registers
    // ------------------------------------------------------------
    // The core clock is the chip clock as it arrives, with no divider.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags_r <= CRF_FLAGS_RST;
            sp_r <= SP_RST;
            ptr_addr_r <= 16'h0000;
            ds_rdata_r <= 8'h00;
            ds_hit_r <= 1'b0;
            irq_ok_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            sp_r <= sp_nxt;
            ptr_addr_r <= ptr_go ? ptr_eff : ptr_addr_r;
            ds_rdata_r <= ds_rd ? rd_val : ds_rdata_r;
            ds_hit_r <= ds_rd && ds_hit;
            irq_ok_r <= flags_r[CRF_FB_I] && irq_req && !gie_clr;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire logic quiet = !ds_wr && !ptr_req;

    chk_sp_push_dec: assert property (@(posedge clk) disable iff (reset)
        (op_valid && op == CRF_OP_PUSH && quiet) |=> sp_r == (($past(sp_r) - 16'h0001) & SP_MASK))
        else $error("stack pointer did not drop by one on push");
    chk_sp_call_dec: assert property (@(posedge clk) disable iff (reset)
        (op_valid && (op inside {CRF_OP_CALL, CRF_OP_IRQ}) && quiet)
        |=> sp_r == (($past(sp_r) - 16'h0002) & SP_MASK))
        else $error("stack pointer did not drop by two on call");
    chk_sp_ret_inc: assert property (@(posedge clk) disable iff (reset)
        (op_valid && (op inside {CRF_OP_RET, CRF_OP_IRET}) && quiet)
        |=> sp_r == (($past(sp_r) + 16'h0002) & SP_MASK))
        else $error("stack pointer did not rise by two on return");
    chk_sign_xor: assert property (@(posedge clk) disable iff (reset)
        flags_r[CRF_FB_S] == (flags_r[CRF_FB_N] ^ flags_r[CRF_FB_V]))
        else $error("sign flag differs from negative xor overflow");
    chk_gie_entry_clr: assert property (@(posedge clk) disable iff (reset)
        (op_valid && op == CRF_OP_IRQ && quiet) |=> !flags_r[CRF_FB_I] ##1 !irq_ok_r)
        else $error("interrupt entry left the global enable set");
    chk_gie_iret_set: assert property (@(posedge clk) disable iff (reset)
        (op_valid && op == CRF_OP_IRET && quiet) |=> flags_r[CRF_FB_I])
        else $error("interrupt return did not set the global enable");
    chk_irq_gated: assert property (@(posedge clk) disable iff (reset)
        irq_ok_r |-> $past(flags_r[CRF_FB_I]) && $past(irq_req))
        else $error("interrupt allowed while globally disabled");
    chk_add_flags: assert property (@(posedge clk) disable iff (reset)
        (op_valid && op == CRF_OP_ADD && quiet)
        |=> flags_r[CRF_FB_Z] == (gpr_r[$past(dst_idx)] == 8'h00)
            && flags_r[CRF_FB_N] == gpr_r[$past(dst_idx)][7])
        else $error("zero or negative flag wrong after add");
    chk_add_result: assert property (@(posedge clk) disable iff (reset)
        (op_valid && op == CRF_OP_ADD && quiet)
        |=> {flags_r[CRF_FB_C], gpr_r[$past(dst_idx)]}
            == {1'b0, $past(alu_bus.a)} + {1'b0, $past(alu_bus.b)})
        else $error("add result or carry not written in one cycle");
    chk_ptr_modes: assert property (@(posedge clk) disable iff (reset)
        (ptr_go && !ds_wr && !op_valid && ptr_mode == CRF_PM_PREDEC)
        |=> ptr_addr_r == $past(ptr_dec) && {gpr_r[$past(ptr_hi)], gpr_r[$past(ptr_lo)]}
            == $past(ptr_dec))
        else $error("pre-decrement pointer address or update wrong");
    chk_reg_mirror: assert property (@(posedge clk) disable iff (reset)
        (ds_rd && ds_gpr) |=> ds_hit_r && ds_rdata_r == $past(rd_gpr))
        else $error("register read through data space wrong");
endmodule

// >>> design/crf_pkg.sv
// Shared constants and types of the core register, flag and stack block
package crf_pkg;
    // ------------------------------------------------------------
    // Data-space map
    // ------------------------------------------------------------
    localparam int CRF_NUM_GPR = 32;
    localparam logic [15:0] CRF_IO_BASE = 16'h0020;
    localparam logic [15:0] CRF_IO_LAST = 16'h005F;
    localparam logic [5:0] CRF_SP_LO_IO = 6'h3D;
    localparam logic [5:0] CRF_SP_HI_IO = 6'h3E;
    localparam logic [5:0] CRF_FLAGS_IO = 6'h3F;
    localparam logic [4:0] CRF_PTR_X = 5'h1A;
    localparam logic [4:0] CRF_MUL_DST = 5'h00;

    // ------------------------------------------------------------
    // Flag bit positions and update masks
    // ------------------------------------------------------------
    localparam int CRF_FB_I = 7;
    localparam int CRF_FB_T = 6;
    localparam int CRF_FB_H = 5;
    localparam int CRF_FB_S = 4;
    localparam int CRF_FB_V = 3;
    localparam int CRF_FB_N = 2;
    localparam int CRF_FB_Z = 1;
    localparam int CRF_FB_C = 0;
    localparam logic [7:0] CRF_M_ARITH = 8'h3F;
    localparam logic [7:0] CRF_M_SVNZC = 8'h1F;
    localparam logic [7:0] CRF_M_SVNZ = 8'h1E;
    localparam logic [7:0] CRF_M_T = 8'h40;
    localparam logic [7:0] CRF_M_ZC = 8'h03;

    // ------------------------------------------------------------
    // Reset values and steps
    // ------------------------------------------------------------
    localparam logic [7:0] CRF_FLAGS_RST = 8'h00;
    localparam logic [7:0] CRF_GPR_RST = 8'h00;
    localparam logic [15:0] CRF_SRAM_TOP_DEF = 16'h04FF;
    localparam int CRF_SP_W_DEF = 16;
    localparam logic [15:0] CRF_STEP_DATA = 16'h0001;
    localparam logic [15:0] CRF_STEP_ADDR = 16'h0002;

    typedef enum logic [4:0] {
        CRF_OP_NOP = 5'b00000, CRF_OP_ADD = 5'b00001, CRF_OP_ADC = 5'b00010,
        CRF_OP_SUB = 5'b00011, CRF_OP_SBC = 5'b00100, CRF_OP_AND = 5'b00101,
        CRF_OP_OR = 5'b00110, CRF_OP_EOR = 5'b00111, CRF_OP_COM = 5'b01000,
        CRF_OP_NEG = 5'b01001, CRF_OP_INC = 5'b01010, CRF_OP_DEC = 5'b01011,
        CRF_OP_LSR = 5'b01100, CRF_OP_ROR = 5'b01101, CRF_OP_ASR = 5'b01110,
        CRF_OP_SWAP = 5'b01111, CRF_OP_MOV = 5'b10000, CRF_OP_BIT_TO_T = 5'b10001,
        CRF_OP_T_TO_BIT = 5'b10010, CRF_OP_MUL = 5'b10011, CRF_OP_ADIW = 5'b10100,
        CRF_OP_SBIW = 5'b10101, CRF_OP_MOVW = 5'b10110, CRF_OP_PUSH = 5'b10111,
        CRF_OP_POP = 5'b11000, CRF_OP_CALL = 5'b11001, CRF_OP_RET = 5'b11010,
        CRF_OP_IRET = 5'b11011, CRF_OP_IRQ = 5'b11100, CRF_OP_SEI = 5'b11101,
        CRF_OP_CLI = 5'b11110
    } crf_op_t;

    typedef enum logic [1:0] {
        CRF_PM_DISP = 2'b00,
        CRF_PM_POSTINC = 2'b01,
        CRF_PM_PREDEC = 2'b10
    } crf_ptr_mode_t;
endpackage

// >>> tb/crf_dec_model.sv
// Behavioural decoder and interrupt source that stand in front of the core
module crf_dec_model
    import crf_pkg::*;
(
    // Clock
    input wire logic clk,
    // Instruction fields
    output logic op_valid,
    output crf_op_t op,
    output logic [4:0] dst_idx,
    output logic [7:0] imm,
    output logic [2:0] bit_sel,
    // Pending interrupt, already gated by its own enable
    output logic irq_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        op_valid = 1'b0;
        op = CRF_OP_NOP;
        dst_idx = 5'h00;
        imm = 8'h00;
        bit_sel = 3'h0;
        irq_req = 1'b0;
    end

    // One instruction per call, valid for exactly one edge
    task automatic go(crf_op_t o, logic [4:0] d, logic [7:0] i, logic [2:0] b);
        @(posedge clk);
        #1;
        op_valid = 1'b1;
        op = o;
        dst_idx = d;
        imm = i;
        bit_sel = b;
        @(posedge clk);
        #1;
        op_valid = 1'b0;
    endtask

    task automatic irq(logic v);
        @(posedge clk);
        #1;
        irq_req = v;
    endtask
endmodule

// >>> tb/tb_cpu_core_regs_flags_stack.sv
// Self-checking bench for the core register, flag and stack block
module tb_cpu_core_regs_flags_stack import crf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] TOP = 16'h08FF;
    typedef struct {crf_op_t op; logic [7:0] a; logic [7:0] b; logic [7:0] r; logic [7:0] f;} crf_row_t;
    crf_row_t rows [8] = '{'{CRF_OP_ADD, 8'h0F, 8'h01, 8'h10, 8'h20},
        '{CRF_OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h2C}, '{CRF_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h23},
        '{CRF_OP_SUB, 8'h00, 8'h01, 8'hFF, 8'h35}, '{CRF_OP_AND, 8'hF0, 8'h80, 8'h80, 8'h14},
        '{CRF_OP_EOR, 8'h55, 8'h55, 8'h00, 8'h02}, '{CRF_OP_COM, 8'h00, 8'h00, 8'hFF, 8'h15},
        '{CRF_OP_LSR, 8'h01, 8'h00, 8'h00, 8'h1B}};
    crf_op_t sops [4] = '{CRF_OP_PUSH, CRF_OP_CALL, CRF_OP_RET, CRF_OP_POP};
    logic [15:0] sdel [4] = '{16'hFFFF, 16'hFFFE, 16'h0002, 16'h0001};
    logic clk, reset, op_valid, ptr_req, ds_rd, ds_wr, ds_hit_r, irq_req, irq_ok_r;
    crf_op_t op;
    crf_ptr_mode_t ptr_mode;
    logic [4:0] dst_idx;
    logic [2:0] bit_sel;
    logic [1:0] ptr_sel;
    logic [5:0] ptr_disp;
    logic [7:0] imm, ds_wdata, ds_rdata_r, flags_r;
    logic [15:0] ds_addr, ptr_addr_r, sp_r, s;
    int miscompares = 0;
    int checked = 0;

    crf_dec_model U (.clk(clk), .op_valid(op_valid), .op(op), .dst_idx(dst_idx), .imm(imm),
        .bit_sel(bit_sel), .irq_req(irq_req));
    crf_core #(.SP_W(16), .SRAM_TOP(TOP)) DUT (.clk(clk), .reset(reset), .op_valid(op_valid),
        .op(op), .dst_idx(dst_idx), .src_idx(5'h00), .imm(imm), .use_imm(1'b1),
        .bit_sel(bit_sel), .ptr_req(ptr_req), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode),
        .ptr_disp(ptr_disp), .ptr_addr_r(ptr_addr_r), .ds_rd(ds_rd), .ds_wr(ds_wr),
        .ds_addr(ds_addr), .ds_wdata(ds_wdata), .ds_rdata_r(ds_rdata_r), .ds_hit_r(ds_hit_r),
        .irq_req(irq_req), .irq_ok_r(irq_ok_r), .flags_r(flags_r), .sp_r(sp_r));

    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic chk(logic [15:0] g, logic [15:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        #1;
        ds_wr = 1'b1;
        ds_addr = a;
        ds_wdata = d;
        @(posedge clk);
        #1;
        ds_wr = 1'b0;
    endtask

    // Leaves the bench one step after the read edge, where the answer stands
    task automatic rd(logic [15:0] a);
        @(posedge clk);
        #1;
        ds_rd = 1'b1;
        ds_addr = a;
        @(posedge clk);
        #1;
        ds_rd = 1'b0;
    endtask

    task automatic pt(logic [1:0] sel, crf_ptr_mode_t m, logic [5:0] d);
        @(posedge clk);
        #1;
        ptr_req = 1'b1;
        ptr_sel = sel;
        ptr_mode = m;
        ptr_disp = d;
        @(posedge clk);
        #1;
        ptr_req = 1'b0;
    endtask

    task automatic results();
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is about 130 cycles; this is over thirty-five times that
    initial begin
        #50000;
        miscompares++;
        results();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {reset, ptr_req, ds_rd, ds_wr, ptr_sel, ptr_disp, ds_addr, ds_wdata} = '0;
        reset = 1'b1;
        ptr_mode = CRF_PM_DISP;
        repeat (4) @(posedge clk);
        #1;
        reset = 1'b0;
        chk(flags_r, 16'h0000);
        chk(sp_r, TOP);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(16'h0010, rows[i].a);
            wr(16'h005F, 8'h00);
            U.go(rows[i].op, 5'h10, rows[i].b, 3'h0);
            rd(16'h0010);
            chk(ds_rdata_r, rows[i].r);
            chk(flags_r, rows[i].f);
        end
        $display("alu table test done");
        U.irq(1'b1);
        wr(16'h005F, 8'h00);
        @(posedge clk);
        #1;
        chk(irq_ok_r, 16'h0000);
        U.go(CRF_OP_SEI, 5'h00, 8'h00, 3'h0);
        chk(flags_r, 16'h0080);
        @(posedge clk);
        #1;
        chk(irq_ok_r, 16'h0001);
        wr(16'h005D, 8'h00);
        wr(16'h005E, 8'h04);
        chk(sp_r, 16'h0400);
        rd(16'h005E);
        chk(ds_rdata_r, 16'h0004);
        chk(ds_hit_r, 16'h0001);
        wr(16'h005F, 8'h83);
        U.go(CRF_OP_IRQ, 5'h00, 8'h00, 3'h0);
        chk(flags_r, 16'h0003);
        chk(sp_r, 16'h03FE);
        U.go(CRF_OP_IRET, 5'h00, 8'h00, 3'h0);
        chk(flags_r, 16'h0083);
        U.go(CRF_OP_CLI, 5'h00, 8'h00, 3'h0);
        chk(flags_r, 16'h0003);
        $display("interrupt test done");
        s = 16'h0400;
        foreach (sops[i]) begin
            s = s + sdel[i];
            U.go(sops[i], 5'h00, 8'h00, 3'h0);
            chk(sp_r, s);
        end
        $display("stack test done");
        wr(16'h0005, 8'h08);
        U.go(CRF_OP_BIT_TO_T, 5'h05, 8'h00, 3'h3);
        chk(flags_r[6], 16'h0001);
        wr(16'h0006, 8'h00);
        U.go(CRF_OP_T_TO_BIT, 5'h06, 8'h00, 3'h0);
        rd(16'h0006);
        chk(ds_rdata_r, 16'h0001);
        wr(16'h0018, 8'hFF);
        wr(16'h0019, 8'h00);
        U.go(CRF_OP_ADIW, 5'h18, 8'h01, 3'h0);
        rd(16'h0019);
        chk(ds_rdata_r, 16'h0001);
        $display("bit copy and word test done");
        wr(16'h001E, 8'hFF);
        wr(16'h001F, 8'h00);
        pt(2'h2, CRF_PM_POSTINC, 6'h00);
        chk(ptr_addr_r, 16'h00FF);
        rd(16'h001F);
        chk(ds_rdata_r, 16'h0001);
        pt(2'h2, CRF_PM_PREDEC, 6'h00);
        chk(ptr_addr_r, 16'h00FF);
        pt(2'h2, CRF_PM_DISP, 6'h05);
        chk(ptr_addr_r, 16'h0104);
        rd(16'h0040);
        chk({ds_hit_r, ds_rdata_r}, 16'h0000);
        $display("pointer test done");
        reset = 1'b1;
        @(posedge clk);
        #1;
        reset = 1'b0;
        chk(flags_r, 16'h0000);
        chk(sp_r, TOP);
        $display("second reset test done");
        results();
    end
endmodule
